// *** core/sdc_ctrl.sv ***
// SDRAM command sequencer: bank tracking, timing gates, refresh and power modes
`default_nettype none
module sdc_ctrl
	import sdc_pkg::*;
#(
	parameter int ROW_W   = 13,
	parameter int COL_W   = 10,
	parameter int DATA_W  = 16,
	parameter int REFI    = T_REFI
) (
	// Clock and reset
	input  wire logic              clk_i,
	input  wire logic              srst_i,
	// User request port
	input  wire logic              req_valid_i,
	input  wire sdc_req_t          req_op_i,
	input  wire logic [1:0]        req_bank_i,
	input  wire logic [ROW_W-1:0]  req_row_i,
	input  wire logic [COL_W-1:0]  req_col_i,
	input  wire logic              req_ap_i,
	input  wire logic [DATA_W-1:0] req_wdata_i,
	output logic                   req_ready_o,
	// Read return
	output logic                   rd_valid_o,
	output logic [DATA_W-1:0]      rd_data_o,
	// Status
	output logic                   self_refresh_o,
	output logic                   deep_down_o,
	// Memory pins
	output logic                   clk_enable_o,
	output logic                   chip_select_n_o,
	output logic                   row_strobe_n_o,
	output logic                   column_strobe_n_o,
	output logic                   write_enable_n_o,
	output logic                   bank_sel_lo_o,
	output logic                   bank_sel_hi_o,
	output logic [ROW_W-1:0]       addr_o,
	output logic                   byte_mask_o,
	input  wire logic [DATA_W-1:0] dq_i,
	output logic [DATA_W-1:0]      dq_o,
	output logic                   dq_oe_n_o
);
	localparam int AP_BIT = 10;
	localparam int RDPIPE = READ_LATENCY + 1;
	if (ROW_W <= AP_BIT || COL_W > ROW_W || REFI < T_RFC + T_RP + 8 || REFI > 65535) begin : g_bad
		$error("sdc_ctrl: unsupported parameters");
	end

	typedef struct packed {
		sdc_mode_t         mode;
		logic [3:0]        open;
		logic [3:0][ROW_W-1:0] row;
		logic [3:0]        cmd;
		logic              cke;
		logic [1:0]        ba;
		logic [ROW_W-1:0]  addr;
		logic              dqm;
		logic              oe_n;
		logic [DATA_W-1:0] wdata;
		logic [15:0]       refi;
		logic              ref_due;
		logic [CNT_W-1:0]  hold;
		logic [RDPIPE-1:0] rd_pipe;
		logic [CNT_W-1:0]  burst_left;
		logic              last_ap;
		logic [CNT_W-1:0]  stop;
		logic              rd_valid;
		logic [DATA_W-1:0] rd_data;
	} sdc_state_t;
	sdc_state_t s_r, s_nxt;

	// Per-bank counters: activate-to-column, row cycle, precharge
	logic [3:0]             rcd_ok, rc_ok, rp_ok;
	logic [3:0]             ld_rcd, ld_rc, ld_rp;
	logic [3:0][CNT_W-1:0]  rp_val;
	logic                   rrd_ok, ld_rrd;
	for (genvar b = 0; b < 4; b++) begin : g_bank
		sdc_down_cnt u_rcd (.clk_i(clk_i), .srst_i(srst_i), .load_i(ld_rcd[b]),
			.val_i(CNT_W'(T_RCD - 1)), .zero_o(rcd_ok[b]));
		sdc_down_cnt u_rc (.clk_i(clk_i), .srst_i(srst_i), .load_i(ld_rc[b]),
			.val_i(CNT_W'(T_RC - 1)), .zero_o(rc_ok[b]));
		sdc_down_cnt u_rp (.clk_i(clk_i), .srst_i(srst_i), .load_i(ld_rp[b]),
			.val_i(rp_val[b]), .zero_o(rp_ok[b]));
	end
	sdc_down_cnt u_rrd (.clk_i(clk_i), .srst_i(srst_i), .load_i(ld_rrd),
		.val_i(CNT_W'(T_RRD - 1)), .zero_o(rrd_ok));

	logic       all_idle, bank_free, need_act, can_go, is_rw, accept, rd_busy;
	logic [1:0] b;
	always_comb begin
		s_nxt    = s_r;
		ld_rcd   = '0;
		ld_rc    = '0;
		ld_rp    = '0;
		rp_val   = '0;
		ld_rrd   = 1'b0;
		b        = req_bank_i;
		all_idle = (s_r.open == 4'h0) && (&rp_ok);
		bank_free = rp_ok[b] && rc_ok[b];
		is_rw    = (req_op_i == SDC_REQ_READ) || (req_op_i == SDC_REQ_WRITE);
		need_act = is_rw && (!s_r.open[b] || (s_r.row[b] != req_row_i));
		can_go   = 1'b0;
		accept   = 1'b0;
		rd_busy  = (s_r.rd_pipe != '0) || (s_r.burst_left != '0);
		s_nxt.cmd  = CMD_NOP;
		s_nxt.addr = '0;
		s_nxt.oe_n = 1'b1;
		s_nxt.dqm  = 1'b0;
		s_nxt.hold = (s_r.hold != '0) ? s_r.hold - 1'b1 : s_r.hold;
		// Read data capture: first word latency after read, burst counter takes the rest
		s_nxt.rd_pipe  = {s_r.rd_pipe[RDPIPE-2:0], 1'b0};
		s_nxt.rd_valid = 1'b0;
		if (s_r.burst_left != '0) begin
			s_nxt.burst_left = s_r.burst_left - 1'b1;
			s_nxt.rd_valid   = 1'b1;
			s_nxt.rd_data    = dq_i;
		end
		if (s_r.rd_pipe[RDPIPE-1]) begin
			s_nxt.burst_left = CNT_W'(BURST_LEN - 1);
			s_nxt.rd_valid   = 1'b1;
			s_nxt.rd_data    = dq_i;
		end
		// After a terminate, only words already inside the latency window arrive
		if (s_r.stop != '0) begin
			s_nxt.stop = s_r.stop - 1'b1;
			if (s_r.stop == CNT_W'(1)) begin
				s_nxt.rd_pipe    = '0;
				s_nxt.burst_left = '0;
			end
		end
		// Refresh interval timer
		if (s_r.refi != '0) begin
			s_nxt.refi = s_r.refi - 1'b1;
		end else begin
			s_nxt.refi    = 16'(REFI - 1);
			s_nxt.ref_due = 1'b1;
		end
		case (s_r.mode)
			SDC_RUN: begin
				if (s_r.ref_due && s_r.hold == '0) begin
					if (s_r.open != 4'h0 && !rd_busy) begin
						s_nxt.cmd          = CMD_PRE;
						s_nxt.addr[AP_BIT] = 1'b1;
						s_nxt.open         = 4'h0;
						ld_rp              = 4'hf;
						for (int i = 0; i < 4; i++) rp_val[i] = CNT_W'(T_RP);
					end else if (all_idle) begin
						s_nxt.cmd     = CMD_REF;
						s_nxt.addr    = '0;
						s_nxt.ref_due = 1'b0;
						s_nxt.hold    = CNT_W'(T_RFC);
					end
				end else if (req_valid_i && s_r.hold == '0) begin
					case (req_op_i)
						SDC_REQ_READ, SDC_REQ_WRITE: begin
							if (need_act && s_r.open[b]) begin
								if (rp_ok[b]) begin
									s_nxt.cmd     = CMD_PRE;
									s_nxt.ba      = b;
									s_nxt.open[b] = 1'b0;
									ld_rp[b]      = 1'b1;
									rp_val[b]     = CNT_W'(T_RP);
								end
							end else if (need_act) begin
								if (bank_free && rrd_ok) begin
									s_nxt.cmd    = CMD_ACT;
									s_nxt.ba     = b;
									s_nxt.addr   = req_row_i;
									s_nxt.open[b] = 1'b1;
									s_nxt.row[b]  = req_row_i;
									ld_rcd[b]    = 1'b1;
									ld_rc[b]     = 1'b1;
									ld_rrd       = 1'b1;
								end
							end else if (rcd_ok[b] && rp_ok[b]) begin
								can_go = 1'b1;
							end
							// Write after a live read burst needs the mask up one clock, three clocks before the write
							if (can_go && req_op_i == SDC_REQ_WRITE &&
								(s_r.rd_pipe != '0 || s_r.burst_left != '0)) begin
								can_go        = 1'b0;
								s_nxt.dqm     = 1'b1;
								s_nxt.rd_pipe = '0;
								s_nxt.burst_left = '0;
								s_nxt.hold    = CNT_W'(2);
							end
							if (can_go) begin
								s_nxt.cmd  = (req_op_i == SDC_REQ_READ) ? CMD_RD : CMD_WR;
								accept     = 1'b1;
								s_nxt.ba   = b;
								s_nxt.addr = ROW_W'(req_col_i);
								s_nxt.addr[AP_BIT] = req_ap_i;
								s_nxt.last_ap = req_ap_i;
								if (req_ap_i) begin
									s_nxt.open[b] = 1'b0;
									ld_rp[b]  = 1'b1;
									rp_val[b] = CNT_W'(BURST_LEN + T_RP);
								end
								if (req_op_i == SDC_REQ_READ) begin
									s_nxt.rd_pipe[0] = 1'b1;
									s_nxt.stop = '0;
								end else begin
									s_nxt.oe_n  = 1'b0;
									s_nxt.wdata = req_wdata_i;
									s_nxt.rd_pipe = '0;
								end
							end
						end
						SDC_REQ_TERM: begin
							accept = 1'b1;
							if (!s_r.last_ap) begin
								s_nxt.cmd = CMD_BT;
								// Latest burst is the one cut; words already in flight drain
								s_nxt.stop = CNT_W'(READ_LATENCY);
							end
						end
						SDC_REQ_PRE: begin
							s_nxt.cmd          = CMD_PRE;
							accept             = 1'b1;
							s_nxt.ba           = b;
							s_nxt.addr[AP_BIT] = req_ap_i;
							for (int i = 0; i < 4; i++) begin
								if (req_ap_i || 2'(i) == b) begin
									s_nxt.open[i] = 1'b0;
									ld_rp[i]  = 1'b1;
									rp_val[i] = CNT_W'(T_RP);
								end
							end
						end
						SDC_REQ_SELF: begin
							if (all_idle) begin
								s_nxt.cmd  = CMD_REF;
								accept     = 1'b1;
								s_nxt.cke  = 1'b0;
								s_nxt.mode = SDC_SELF;
								s_nxt.hold = CNT_W'(T_RAS);
							end
						end
						SDC_REQ_DEEP: begin
							if (all_idle) begin
								s_nxt.cmd  = CMD_BT;
								accept     = 1'b1;
								s_nxt.cke  = 1'b0;
								s_nxt.mode = SDC_DEEP;
							end
						end
						default: begin
							accept = 1'b1;
						end
					endcase
				end
			end
			SDC_SELF: begin
				s_nxt.cmd = CMD_DES;
				s_nxt.refi = 16'(REFI - 1);
				s_nxt.ref_due = 1'b0;
				if (req_valid_i && req_op_i == SDC_REQ_WAKE && s_r.hold == '0) begin
					s_nxt.cke  = 1'b1;
					accept     = 1'b1;
					s_nxt.cmd  = CMD_NOP;
					s_nxt.mode = SDC_EXIT;
					s_nxt.hold = CNT_W'(T_XSR);
				end
			end
			SDC_DEEP: begin
				s_nxt.cmd = CMD_DES;
				s_nxt.ref_due = 1'b0;
				if (req_valid_i && req_op_i == SDC_REQ_WAKE) begin
					s_nxt.cke  = 1'b1;
					accept     = 1'b1;
					s_nxt.cmd  = CMD_NOP;
					s_nxt.mode = SDC_RUN;
				end
			end
			SDC_EXIT: begin
				if (s_r.hold <= CNT_W'(1)) begin
					s_nxt.mode    = SDC_RUN;
					s_nxt.ref_due = 1'b1;
				end
			end
			default: s_nxt.mode = SDC_RUN;
		endcase
	end
	// Reset leaves the device selected with nops and the clock enabled
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			s_r      <= '0;
			s_r.cke  <= 1'b1;
			s_r.cmd  <= CMD_NOP;
			s_r.oe_n <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end
	assign req_ready_o       = accept;
	assign rd_valid_o        = s_r.rd_valid;
	assign rd_data_o         = s_r.rd_data;
	assign self_refresh_o    = (s_r.mode == SDC_SELF);
	assign deep_down_o       = (s_r.mode == SDC_DEEP);
	assign clk_enable_o      = s_r.cke;
	assign chip_select_n_o   = s_r.cmd[3];
	assign row_strobe_n_o    = s_r.cmd[2];
	assign column_strobe_n_o = s_r.cmd[1];
	assign write_enable_n_o  = s_r.cmd[0];
	assign bank_sel_lo_o     = s_r.ba[0];
	assign bank_sel_hi_o     = s_r.ba[1];
	assign addr_o            = s_r.addr;
	assign byte_mask_o       = s_r.dqm;
	assign dq_o              = s_r.wdata;
	assign dq_oe_n_o         = s_r.oe_n;

	default clocking cb_main @(posedge clk_i); endclocking
	default disable iff (srst_i);
	sequence s_self_wake;
		(s_r.mode == SDC_EXIT) && $rose(s_r.cke);
	endsequence
	sequence s_nop_pair;
		(s_r.cmd == CMD_NOP) [*2];
	endsequence
	property p_exit_nop;
		s_self_wake |-> s_nop_pair;
	endproperty
	a_exit_nop: assert property (p_exit_nop) else $error("command during self refresh exit");
	property p_rd_latency;
		(s_r.cmd == CMD_RD) ##1 ((s_r.cmd != CMD_WR) && !s_r.dqm) [*3] |=> s_r.rd_valid;
	endproperty
	a_rd_latency: assert property (p_rd_latency) else $error("read word not captured");
	property p_act_spacing;
		(s_r.cmd == CMD_ACT) |=> (s_r.cmd != CMD_ACT);
	endproperty
	a_act_spacing: assert property (p_act_spacing) else $error("activates too close");
	property p_wr_unmasked;
		(s_r.cmd == CMD_WR) |-> !s_r.dqm;
	endproperty
	a_wr_unmasked: assert property (p_wr_unmasked) else $error("write issued with mask high");
endmodule : sdc_ctrl
`default_nettype wire

// *** core/sdc_down_cnt.sv ***
// Loadable down-counter with zero flag, one per bank for T_RCD, T_RC and T_RP plus one for T_RRD
`default_nettype none
module sdc_down_cnt
	import sdc_pkg::*;
#(
	parameter int W = CNT_W
) (
	// Clock and reset
	input  wire logic         clk_i,
	input  wire logic         srst_i,
	// Control
	input  wire logic         load_i,
	input  wire logic [W-1:0] val_i,
	// Status
	output logic              zero_o
);
	typedef struct packed {
		logic [W-1:0] cnt;
	} sdc_cnt_t;
	sdc_cnt_t s_r, s_nxt;
	always_comb begin
		s_nxt = s_r;
		if (load_i && (val_i > s_r.cnt)) begin
			s_nxt.cnt = val_i;
		end else if (s_r.cnt != '0) begin
			s_nxt.cnt = s_r.cnt - 1'b1;
		end
	end
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end
	assign zero_o = (s_r.cnt == '0);
	property p_load_max;
		@(posedge clk_i) disable iff (srst_i)
		load_i && (val_i > s_r.cnt) |=> (s_r.cnt == $past(val_i));
	endproperty
	a_load_max: assert property (p_load_max) else $error("counter missed a load");
	property p_step_down;
		@(posedge clk_i) disable iff (srst_i)
		!load_i && (s_r.cnt != '0) |=> (s_r.cnt == $past(s_r.cnt) - 1'b1);
	endproperty
	a_step_down: assert property (p_step_down) else $error("counter did not step");
endmodule : sdc_down_cnt
`default_nettype wire

// *** core/sdc_pkg.sv ***
// Package of command codes, timing constants and states for the SDRAM command sequencer
`default_nettype none
package sdc_pkg;
	localparam int CLK_PERIOD_NS = 10;
	// Timing figures in ns (refresh interval in ps, period in ms); counts derived by rounding up except T_REFI
	localparam int ROW_PRECHARGE_TIME_NS  = 18;
	localparam int ROW_TO_COLUMN_DELAY_NS = 18;
	localparam int ROW_CYCLE_TIME_NS      = 60;
	localparam int ROW_TO_ROW_DELAY_NS    = 12;
	localparam int ROW_ACTIVE_TIME_NS     = 42;
	localparam int SELF_REFRESH_EXIT_NS   = 112;
	localparam int REFRESH_CYCLE_NS       = 72;
	localparam int REFRESH_INTERVAL_PS    = 7812500;
	localparam int REFRESH_PERIOD_MS      = 64;
	localparam int REFRESH_COUNT          = 8192;
	localparam int T_RP   = (ROW_PRECHARGE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int T_RCD  = (ROW_TO_COLUMN_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int T_RC   = (ROW_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int T_RRD  = (ROW_TO_ROW_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int T_RAS  = (ROW_ACTIVE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int T_XSR0 = (SELF_REFRESH_EXIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int T_XSR  = (T_XSR0 < 2) ? 2 : T_XSR0;
	localparam int T_RFC  = (REFRESH_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Longest time, rounded down
	localparam int T_REFI = REFRESH_INTERVAL_PS / (CLK_PERIOD_NS * 1000);
	localparam int READ_LATENCY = 3;
	localparam int BURST_LEN    = 4;
	localparam int CNT_W        = 8;
	// Command codes {cs_n, ras_n, cas_n, we_n}
	localparam logic [3:0] CMD_NOP = 4'h7;
	localparam logic [3:0] CMD_ACT = 4'h3;
	localparam logic [3:0] CMD_RD  = 4'h5;
	localparam logic [3:0] CMD_WR  = 4'h4;
	localparam logic [3:0] CMD_BT  = 4'h6;
	localparam logic [3:0] CMD_PRE = 4'h2;
	localparam logic [3:0] CMD_REF = 4'h1;
	localparam logic [3:0] CMD_DES = 4'h8;
	// User requests
	typedef enum logic [2:0] {
		SDC_REQ_NONE, SDC_REQ_READ, SDC_REQ_WRITE, SDC_REQ_TERM,
		SDC_REQ_PRE, SDC_REQ_SELF, SDC_REQ_DEEP, SDC_REQ_WAKE
	} sdc_req_t;
	typedef enum {
		SDC_RUN, SDC_SELF, SDC_DEEP, SDC_EXIT
	} sdc_mode_t;
endpackage : sdc_pkg
`default_nettype wire

// *** tb/sdc_mem_model.sv ***
// Behavioural four-bank SDRAM device that answers the sequencer and counts misuse
`default_nettype none
module sdc_mem_model
	import sdc_pkg::*;
#(
	parameter int REFI = T_REFI
) (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        srst_i,
	// Command pins
	input  wire logic        clk_enable_i,
	input  wire logic [3:0]  cmd_i,
	input  wire logic [1:0]  bank_i,
	input  wire logic [12:0] addr_i,
	input  wire logic        byte_mask_i,
	// Data bus and counts
	input  wire logic [15:0] dq_i,
	input  wire logic        dq_oe_n_i,
	output logic [15:0]      dq_o,
	output int               err_o,
	output int               ref_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int          cyc = 0;
	int          act_t[4] = '{default: -99};
	int          pre_t[4] = '{default: -99};
	int          any_act = -99;
	int          ref_t = 0;
	int          sr_t = 0;
	int          xsr = 0;
	logic [3:0]  open_r = 4'h0;
	logic        self_r = 1'b0;
	logic        deep_r = 1'b0;
	logic        ap_r = 1'b0;
	logic [1:0]  rd_b = 2'h0;
	logic [1:0]  b;
	logic [15:0] last = 16'h0000;
	// Slot 0 drives the bus up to the next edge: {valid, float, word}
	logic [17:0] slot[8] = '{default: 18'h00000};
	logic [15:0] mem[logic [11:0]];
	initial err_o = 0;
	initial ref_o = 0;
	initial dq_o = 16'h0000;
	function automatic logic [15:0] word(input logic [1:0] bk, input logic [9:0] c);
		return mem.exists({bk, c}) ? mem[{bk, c}] : {2'b10, bk, 2'b00, c};
	endfunction : word
	task automatic cut(input int from);
		for (int j = from; j < 8; j++) slot[j] = 18'h00000;
	endtask : cut
	always @(posedge clk_i) begin
		b = bank_i;
		cyc++;
		if (!dq_oe_n_i && slot[0][17] && !slot[0][16]) err_o++;
		for (int j = 0; j < 7; j++) slot[j] = slot[j + 1];
		slot[7] = 18'h00000;
		if (byte_mask_i) slot[1][16] = 1'b1;
		if (srst_i || self_r || deep_r || cyc - ref_t > REFI + 40) begin
			if (cyc - ref_t > REFI + 40) err_o++;
			ref_t = cyc;
		end
		if (self_r || deep_r) begin
			if (clk_enable_i) begin
				if (self_r && cyc - sr_t < T_RAS) err_o++;
				xsr = self_r ? T_XSR - 1 : 0;
				self_r = 1'b0;
				deep_r = 1'b0;
			end
		end else if (!clk_enable_i && cmd_i == CMD_REF) begin
			self_r = 1'b1;
			sr_t = cyc;
		end else if (!clk_enable_i && cmd_i == CMD_BT) begin
			deep_r = 1'b1;
			if (open_r != 4'h0) err_o++;
		end else if (xsr > 0) begin
			xsr--;
			if (!cmd_i[3] && cmd_i != CMD_NOP) err_o++;
		end else if (clk_enable_i && !cmd_i[3]) begin
			case (cmd_i)
			CMD_ACT: begin
				if (open_r[b] || cyc - act_t[b] < T_RC || cyc - pre_t[b] < T_RP) err_o++;
				if (cyc - any_act < T_RRD) err_o++;
				open_r[b] = 1'b1;
				act_t[b] = cyc;
				any_act = cyc;
			end
			CMD_RD, CMD_WR: begin
				if (!open_r[b] || cyc - act_t[b] < T_RCD) err_o++;
				ap_r = addr_i[10];
				if (ap_r) open_r[b] = 1'b0;
				if (ap_r) pre_t[b] = cyc + BURST_LEN;
				rd_b = b;
				cut(READ_LATENCY - 1);
				if (cmd_i == CMD_WR) cut(0);
				if (cmd_i == CMD_WR && byte_mask_i) err_o++;
				if (cmd_i == CMD_WR) mem[{b, addr_i[9:0]}] = dq_i;
				for (int j = 0; j < BURST_LEN && cmd_i == CMD_RD; j++)
					slot[READ_LATENCY - 1 + j] = {2'b10, word(b, addr_i[9:0] + 10'(j))};
			end
			CMD_BT: begin
				if (ap_r) err_o++;
				cut(READ_LATENCY - 1);
			end
			CMD_PRE: begin
				if (addr_i[10] || b == rd_b) cut(READ_LATENCY - 1);
				for (int k = 0; k < 4; k++) begin
					if (addr_i[10] || k == b) open_r[k] = 1'b0;
					if (addr_i[10] || k == b) pre_t[k] = cyc;
				end
			end
			CMD_REF: begin
				for (int k = 0; k < 4; k++)
					if (open_r[k] || cyc - pre_t[k] < T_RP) err_o++;
				ref_o++;
				ref_t = cyc;
			end
			default: ;
			endcase
		end
		// A floating bus toggles so a stale word never looks valid
		last = (slot[0][17] && !slot[0][16]) ? slot[0][15:0] : ~last;
		dq_o <= last;
	end
endmodule : sdc_mem_model
`default_nettype wire

// *** tb/test_sdram_command_sequencing.sv ***
// Self-checking bench for the SDRAM command sequencer
`default_nettype none
module test_sdram_command_sequencing
	import sdc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int REFI = 100;
	logic        clk_i = 1'b0;
	logic        srst_i = 1'b1;
	logic        req_valid_i = 1'b0;
	sdc_req_t    req_op_i = SDC_REQ_NONE;
	logic [1:0]  req_bank_i = 2'h0;
	logic [12:0] req_row_i = 13'h0000;
	logic [9:0]  req_col_i = 10'h000;
	logic        req_ap_i = 1'b0;
	logic [15:0] req_wdata_i = 16'h0000;
	logic        req_ready_o, rd_valid_o, self_refresh_o, deep_down_o, clk_enable_o;
	logic        chip_select_n_o, row_strobe_n_o, column_strobe_n_o, write_enable_n_o;
	logic        bank_sel_lo_o, bank_sel_hi_o, byte_mask_o, dq_oe_n_o;
	logic [12:0] addr_o;
	logic [15:0] rd_data_o, dq_o, m_dq, dq_w;
	int          fail_count = 0;
	int          cmp_count = 0;
	int          m_err, m_ref, r0;
	logic [15:0] rq[$];
	assign dq_w = (dq_oe_n_o === 1'b0) ? dq_o : m_dq;
	sdc_ctrl #(.REFI(REFI)) uut (
		.clk_i, .srst_i, .req_valid_i, .req_op_i, .req_bank_i, .req_row_i, .req_col_i,
		.req_ap_i, .req_wdata_i, .req_ready_o, .rd_valid_o, .rd_data_o, .self_refresh_o,
		.deep_down_o, .clk_enable_o, .chip_select_n_o, .row_strobe_n_o, .column_strobe_n_o,
		.write_enable_n_o, .bank_sel_lo_o, .bank_sel_hi_o, .addr_o, .byte_mask_o,
		.dq_i(dq_w), .dq_o, .dq_oe_n_o
	);
	sdc_mem_model #(.REFI(REFI)) dev (
		.clk_i, .srst_i, .clk_enable_i(clk_enable_o), .addr_i(addr_o),
		.cmd_i({chip_select_n_o, row_strobe_n_o, column_strobe_n_o, write_enable_n_o}),
		.bank_i({bank_sel_hi_o, bank_sel_lo_o}), .byte_mask_i(byte_mask_o),
		.dq_i(dq_w), .dq_oe_n_i(dq_oe_n_o), .dq_o(m_dq), .err_o(m_err), .ref_o(m_ref)
	);
	initial begin
		forever #5 clk_i = ~clk_i;
	end
	always @(negedge clk_i)
		if (rd_valid_o === 1'b1) rq.push_back(rd_data_o);
	function automatic logic [15:0] pat(input logic [1:0] bk, input logic [9:0] c);
		return {2'b10, bk, 2'b00, c};
	endfunction : pat
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic req(input sdc_req_t op, input logic [1:0] b = 2'h0,
			input logic [9:0] c = 10'h000, input logic ap = 1'b0, input logic [15:0] wd = 16'h0000);
		logic r;
		r = 1'b0;
		@(posedge clk_i);
		req_valid_i <= 1'b1;
		req_op_i <= op;
		req_bank_i <= b;
		req_row_i <= {11'h010, b};
		req_col_i <= c;
		req_ap_i <= ap;
		req_wdata_i <= wd;
		for (int n = 0; n < 500 && r !== 1'b1; n++) begin
			@(negedge clk_i);
			r = req_ready_o;
			@(posedge clk_i);
		end
		req_valid_i <= 1'b0;
		chk(r, 1'b1);
	endtask : req
	task automatic wait_rd(input int n);
		for (int k = 0; k < 100 && rq.size() < n; k++) @(posedge clk_i);
		repeat (8) @(posedge clk_i);
	endtask : wait_rd
	task automatic t_read(input logic [9:0] c);
		rq.delete();
		req(SDC_REQ_READ, 2'h1, c);
		wait_rd(4);
		chk(rq.size(), 4);
		foreach (rq[j]) chk(rq[j], pat(2'h1, c + 10'(j)));
	endtask : t_read
	task automatic t_wr_rd();
		rq.delete();
		req(SDC_REQ_WRITE, 2'h2, 10'h020, 1'b0, 16'h5a5a);
		req(SDC_REQ_READ, 2'h2, 10'h020, 1'b1);
		req(SDC_REQ_READ, 2'h2, 10'h024);
		wait_rd(8);
		chk(rq[0], 16'h5a5a);
		chk(rq[rq.size() - 4], pat(2'h2, 10'h024));
	endtask : t_wr_rd
	task automatic t_rr();
		rq.delete();
		req(SDC_REQ_READ, 2'h3, 10'h040);
		req(SDC_REQ_READ, 2'h3, 10'h080);
		wait_rd(5);
		chk(rq[0], pat(2'h3, 10'h040));
		for (int j = 0; j < 4; j++) chk(rq[rq.size() - 4 + j], pat(2'h3, 10'h080 + 10'(j)));
	endtask : t_rr
	task automatic t_term();
		rq.delete();
		req(SDC_REQ_READ, 2'h1, 10'h100);
		req(SDC_REQ_TERM);
		wait_rd(1);
		chk(rq.size() < 4, 1'b1);
		chk(rq[0], pat(2'h1, 10'h100));
		req(SDC_REQ_PRE, 2'h0, 10'h000, 1'b1);
		t_read(10'h030);
	endtask : t_term
	task automatic t_power(input sdc_req_t op);
		req(op);
		for (int k = 0; k < 50 && (self_refresh_o | deep_down_o) !== 1'b1; k++) @(negedge clk_i);
		chk({self_refresh_o, deep_down_o}, {op == SDC_REQ_SELF, op == SDC_REQ_DEEP});
		chk(clk_enable_o, 1'b0);
		repeat (20) @(posedge clk_i);
		req(SDC_REQ_WAKE);
		for (int k = 0; k < 50 && (self_refresh_o | deep_down_o) !== 1'b0; k++) @(negedge clk_i);
		chk(clk_enable_o, 1'b1);
	endtask : t_power
	task automatic summarize();
		$display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : summarize
	initial begin
		repeat (16) @(posedge clk_i);
		srst_i <= 1'b0;
		t_read(10'h010);
		t_wr_rd();
		t_rr();
		t_term();
		@(negedge clk_i);
		r0 = m_ref;
		repeat (3 * REFI) @(negedge clk_i);
		chk(m_ref - r0 >= 2, 1'b1);
		t_power(SDC_REQ_SELF);
		t_read(10'h050);
		@(negedge clk_i);
		r0 = m_ref;
		repeat (2 * REFI) @(negedge clk_i);
		chk(m_ref - r0 >= 1, 1'b1);
		t_power(SDC_REQ_DEEP);
		chk(m_err, 0);
		summarize();
	end
	// Whole run needs about a thousand cycles; this cuts a hang short
	initial begin
		#200000;
		fail_count++;
		summarize();
	end
endmodule : test_sdram_command_sequencing
`default_nettype wire
